// ==== design/tdct_pkg.sv ====
// Behaviour
// - Three independent 16-bit timers, one shared clock
// - Timers one, two have modes; three free-runs
// - One-shot timer halts at zero, no restart
// - Auto-repeat reloads start value at zero, loops
// - Start value written while running affects restart only
// - Auto-repeat uses newest start value on reload
// - Mode bit: 0 one-shot, 1 auto-repeat, reset 0
// - Timer one enable starts/stops counting, reset 0
// - Timer one counts from start, reset ffff, event
// - Timer two counts from start, reset ffff, event
// - Timer two enable starts/stops counting, reset 0
// - Status flags: timer one bit 0, two bit 1
// - Status read returns flags then clears them
// - Divider code halves rate, 16 kHz to 125 Hz
// - Divider fields reset to code 100 (1 kHz)
// - Timer three runs while enabled, enable resets 0
// - Timer three count read-only, resets to zero
package tdct_pkg;

  // Byte addresses of the register words
  localparam logic [5:0] ADDR_ONE_CONTROL = 6'h00;
  localparam logic [5:0] ADDR_ONE_START = 6'h04;
  localparam logic [5:0] ADDR_TWO_CONTROL = 6'h08;
  localparam logic [5:0] ADDR_TWO_START = 6'h0c;
  localparam logic [5:0] ADDR_FLAGS = 6'h10;
  localparam logic [5:0] ADDR_ONE_DIVIDER = 6'h14;
  localparam logic [5:0] ADDR_TWO_DIVIDER = 6'h18;
  localparam logic [5:0] ADDR_THREE_CONTROL = 6'h1c;
  localparam logic [5:0] ADDR_THREE_COUNT = 6'h20;
  localparam logic [5:0] ADDR_THREE_DIVIDER = 6'h24;

  // Field positions
  localparam int BIT_DOWN_ENABLE = 15;
  localparam int BIT_DOWN_MODE = 14;
  localparam int BIT_THREE_ENABLE = 0;
  localparam int BIT_FLAG_ONE = 0;
  localparam int BIT_FLAG_TWO = 1;

  // Reset values and encodings
  localparam logic MODE_ONE_SHOT = 1'b0;
  localparam logic MODE_REPEAT = 1'b1;
  localparam logic [15:0] START_RESET = 16'hffff;
  localparam logic [2:0] DIV_RESET = 3'h4;

  // Shared counting clock: fastest tick rate and system clock
  localparam int CLK_HZ = 20000000;
  localparam int BASE_TICK_HZ = 16000;
  localparam logic [10:0] BASE_DIV_LAST = 11'(CLK_HZ / BASE_TICK_HZ - 1);

  typedef struct packed {
    logic en;
    logic mode;
    logic [15:0] start;
    logic [2:0] div;
    logic [15:0] cnt;
  } tdct_down_t;

  typedef struct packed {
    logic [10:0] baseCnt;
    logic [6:0] stage;
    tdct_down_t [1:0] down;
    logic t3En;
    logic [2:0] t3Div;
    logic [15:0] t3Cnt;
    logic [1:0] flags;
    logic [1:0] irq;
    logic ack;
    logic [31:0] rdat;
  } tdct_state_t;

  localparam tdct_down_t DOWN_RESET = '{en: 1'b0, mode: MODE_ONE_SHOT, start: START_RESET,
                                        div: DIV_RESET, cnt: 16'h0000};

  localparam tdct_state_t STATE_RESET = '{baseCnt: 11'h000, stage: 7'h00,
                                          down: {DOWN_RESET, DOWN_RESET},
                                          t3En: 1'b0, t3Div: DIV_RESET, t3Cnt: 16'h0000,
                                          flags: 2'h0, irq: 2'h0, ack: 1'b0,
                                          rdat: 32'h00000000};

endpackage : tdct_pkg

// ==== design/tdct_timer.sv ====
`timescale 1ns/1ns
module tdct_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timer events
  output logic timerOneIrq,
  output logic timerTwoIrq
);

  logic [1:0] rstPipe_reg;
  logic rstN;
  tdct_pkg::tdct_state_t st_reg;
  tdct_pkg::tdct_state_t st_next;
  logic baseTick;
  logic access;
  logic wrAccess;
  logic rdAccess;
  logic [1:0] setFlags;
  logic [1:0] clrFlags;
  logic [15:0] image;
  logic [15:0] merged;

  // True when the shared stage counter marks a tick for this divider code
  function automatic logic tickFor(input logic base, input logic [6:0] stage,
                                   input logic [2:0] code);
    logic [6:0] mask;
    mask = 7'((8'h01 << code) - 8'h01);
    return base && ((stage & mask) == mask);
  endfunction : tickFor

  // Byte-lane merge of a write into a 16-bit register image
  function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [15:0] wdat,
                                            input logic [1:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction : laneMerge

  function automatic logic [15:0] controlImage(input tdct_pkg::tdct_down_t t);
    logic [15:0] res;
    res = 16'h0000;
    res[tdct_pkg::BIT_DOWN_ENABLE] = t.en;
    res[tdct_pkg::BIT_DOWN_MODE] = t.mode;
    return res;
  endfunction : controlImage

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstPipe_reg <= 2'h0;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end

  assign rstN = rstPipe_reg[1];

  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.irq = 2'h0;
    setFlags = 2'h0;
    clrFlags = 2'h0;
    image = 16'h0000;
    merged = 16'h0000;

    // Shared prescaler: one base tick at the fastest rate, then a binary stage
    baseTick = (st_reg.baseCnt == tdct_pkg::BASE_DIV_LAST);
    if (baseTick) begin
      st_next.baseCnt = 11'h000;
      st_next.stage = st_reg.stage + 7'h01;
    end else begin
      st_next.baseCnt = st_reg.baseCnt + 11'h001;
    end

    // Down-counting timers one and two
    for (int i = 0; i < 2; i++) begin
      if (st_reg.down[i].en && tickFor(baseTick, st_reg.stage, st_reg.down[i].div)) begin
        if (st_reg.down[i].cnt == 16'h0001) begin
          st_next.down[i].cnt = 16'h0000;
          setFlags[i] = 1'b1;
        end else if (st_reg.down[i].cnt == 16'h0000) begin
          if (st_reg.down[i].mode == tdct_pkg::MODE_REPEAT) begin
            st_next.down[i].cnt = st_reg.down[i].start;
          end else begin
            st_next.down[i].cnt = 16'h0000;
          end
        end else begin
          st_next.down[i].cnt = st_reg.down[i].cnt - 16'h0001;
        end
      end
    end

    // Free-running timer three
    if (st_reg.t3En && tickFor(baseTick, st_reg.stage, st_reg.t3Div)) begin
      st_next.t3Cnt = st_reg.t3Cnt + 16'h0001;
    end

    // Bus access, answered one cycle after the request is seen
    access = wb_cyc_i && wb_stb_i && !st_reg.ack;
    wrAccess = access && wb_we_i;
    rdAccess = access && !wb_we_i;
    st_next.ack = access;

    if (wrAccess) begin
      unique case (wb_adr_i)
        tdct_pkg::ADDR_ONE_CONTROL, tdct_pkg::ADDR_TWO_CONTROL: begin
          for (int i = 0; i < 2; i++) begin
            if ((i == 0) == (wb_adr_i == tdct_pkg::ADDR_ONE_CONTROL)) begin
              image = controlImage(st_reg.down[i]);
              merged = laneMerge(image, wb_dat_i[15:0], wb_sel_i[1:0]);
              st_next.down[i].en = merged[tdct_pkg::BIT_DOWN_ENABLE];
              st_next.down[i].mode = merged[tdct_pkg::BIT_DOWN_MODE];
              if (merged[tdct_pkg::BIT_DOWN_ENABLE] && !st_reg.down[i].en) begin
                st_next.down[i].cnt = st_reg.down[i].start;
              end
            end
          end
        end
        tdct_pkg::ADDR_ONE_START: begin
          st_next.down[0].start = laneMerge(st_reg.down[0].start, wb_dat_i[15:0],
                                            wb_sel_i[1:0]);
        end
        tdct_pkg::ADDR_TWO_START: begin
          st_next.down[1].start = laneMerge(st_reg.down[1].start, wb_dat_i[15:0],
                                            wb_sel_i[1:0]);
        end
        tdct_pkg::ADDR_ONE_DIVIDER: begin
          if (wb_sel_i[0]) begin
            st_next.down[0].div = wb_dat_i[2:0];
          end
        end
        tdct_pkg::ADDR_TWO_DIVIDER: begin
          if (wb_sel_i[0]) begin
            st_next.down[1].div = wb_dat_i[2:0];
          end
        end
        tdct_pkg::ADDR_THREE_CONTROL: begin
          if (wb_sel_i[0]) begin
            st_next.t3En = wb_dat_i[tdct_pkg::BIT_THREE_ENABLE];
          end
        end
        tdct_pkg::ADDR_THREE_DIVIDER: begin
          if (wb_sel_i[0]) begin
            st_next.t3Div = wb_dat_i[2:0];
          end
        end
        default: begin
          // Status, count and unmapped words ignore writes
        end
      endcase
    end

    if (rdAccess) begin
      unique case (wb_adr_i)
        tdct_pkg::ADDR_ONE_CONTROL: begin
          st_next.rdat = {16'h0000, controlImage(st_reg.down[0])};
        end
        tdct_pkg::ADDR_TWO_CONTROL: begin
          st_next.rdat = {16'h0000, controlImage(st_reg.down[1])};
        end
        tdct_pkg::ADDR_ONE_START: begin
          st_next.rdat = {16'h0000, st_reg.down[0].start};
        end
        tdct_pkg::ADDR_TWO_START: begin
          st_next.rdat = {16'h0000, st_reg.down[1].start};
        end
        tdct_pkg::ADDR_FLAGS: begin
          st_next.rdat = {30'h00000000, st_reg.flags};
          clrFlags = 2'h3;
        end
        tdct_pkg::ADDR_ONE_DIVIDER: begin
          st_next.rdat = {29'h00000000, st_reg.down[0].div};
        end
        tdct_pkg::ADDR_TWO_DIVIDER: begin
          st_next.rdat = {29'h00000000, st_reg.down[1].div};
        end
        tdct_pkg::ADDR_THREE_CONTROL: begin
          st_next.rdat = {31'h00000000, st_reg.t3En};
        end
        tdct_pkg::ADDR_THREE_COUNT: begin
          st_next.rdat = {16'h0000, st_reg.t3Cnt};
        end
        tdct_pkg::ADDR_THREE_DIVIDER: begin
          st_next.rdat = {29'h00000000, st_reg.t3Div};
        end
        default: begin
          st_next.rdat = 32'h00000000;
        end
      endcase
    end

    // A completion in the clearing cycle survives the clear
    st_next.flags = (st_reg.flags & ~clrFlags) | setFlags;
    st_next.irq = setFlags;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st_reg <= tdct_pkg::STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = st_reg.rdat;
  assign wb_ack_o = st_reg.ack;
  assign timerOneIrq = st_reg.irq[tdct_pkg::BIT_FLAG_ONE];
  assign timerTwoIrq = st_reg.irq[tdct_pkg::BIT_FLAG_TWO];

endmodule : tdct_timer

// ==== verification/tdct_timer_sva.sv ====
`timescale 1ns/1ns
module tdct_timer_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Timer events
  input wire logic timerOneIrq,
  input wire logic timerTwoIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  a_req_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_flags_hi: assert property (wb_ack_o && !wb_we_i && wb_adr_i == tdct_pkg::ADDR_FLAGS
    |-> wb_dat_o[15:2] == 14'h0000) else $error("flag reserved bits set");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i
    && wb_adr_i > tdct_pkg::ADDR_THREE_DIVIDER |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  a_irq_one_pulse: assert property ($rose(timerOneIrq) |=> !timerOneIrq [*8])
    else $error("timer one event not a pulse");
  a_irq_two_pulse: assert property ($rose(timerTwoIrq) |=> !timerTwoIrq [*8])
    else $error("timer two event not a pulse");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_irq_one: cover property (timerOneIrq);
  c_irq_two: cover property (timerTwoIrq);
endmodule : tdct_timer_chk
bind tdct_timer tdct_timer_chk chk_u (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timerOneIrq(timerOneIrq), .timerTwoIrq(timerTwoIrq));

// ==== verification/tb.sv ====
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] datI = 32'h00000000;
  logic [31:0] datO, rd, prev;
  logic ack, irqOne, irqTwo;
  localparam int TICK = tdct_pkg::CLK_HZ / tdct_pkg::BASE_TICK_HZ;
  logic [15:0] lfsr = 16'hbab4;
  // Register model, one image per word, starting from the reset values
  logic [15:0] model [11] = '{16'h0000, tdct_pkg::START_RESET, 16'h0000,
    tdct_pkg::START_RESET, 16'h0000, {13'h0000, tdct_pkg::DIV_RESET},
    {13'h0000, tdct_pkg::DIV_RESET}, 16'h0000, 16'h0000, {13'h0000, tdct_pkg::DIV_RESET},
    16'h0000};
  int failures = 0;
  int comparisons = 0;
  int now = 0;
  int oneCount = 0;
  int oneTime = 0;
  int t0, t1, tEn, s1;
  logic inWin;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    now <= now + 1;
    if (irqOne === 1'b1) begin
      oneCount <= oneCount + 1;
      oneTime <= now;
    end
  end
  tdct_timer dut_u (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .timerOneIrq(irqOne), .timerTwoIrq(irqTwo));
  task automatic tally_and_finish;
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Writable bits of each register word
  function automatic logic [15:0] rwMask(input int idx);
    case (idx)
      0, 2: return (16'h0001 << tdct_pkg::BIT_DOWN_ENABLE) | (16'h0001 << tdct_pkg::BIT_DOWN_MODE);
      1, 3: return 16'hffff;
      5, 6, 9: return 16'h0007;
      7: return 16'h0001 << tdct_pkg::BIT_THREE_ENABLE;
      default: return 16'h0000;
    endcase
  endfunction : rwMask
  function automatic logic [15:0] nextLfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nextLfsr
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    logic [15:0] m;
    n = 0;
    m = rwMask(int'(a >> 2));
    @(posedge clk);
    {cyc, stb, we, adr, sel, datI} <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = datO;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1) begin
      failures++;
      $display("FAIL %0t bus access not answered", $time);
      tally_and_finish();
    end
    if (w && a[1:0] == 2'h0 && a < 6'h28) begin
      model[a >> 2] = (model[a >> 2] & ~m) | (d[15:0] & m);
    end
  endtask : wb
  task automatic waitTwo(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irqTwo !== 1'b1 && n < 30000);
    t = now;
    if (irqTwo !== 1'b1) begin
      failures++;
      $display("FAIL %0t timer two event missing", $time);
      tally_and_finish();
    end
  endtask : waitTwo
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      wb(1'b0, 6'(i * 4), 32'h0);
      chk(rd, 32'(model[i]));
    end
    lfsr = nextLfsr(lfsr);
    s1 = 2 + int'(lfsr[1:0]);
    wb(1'b1, tdct_pkg::ADDR_ONE_START, {lfsr, 16'(s1)});
    wb(1'b1, tdct_pkg::ADDR_ONE_DIVIDER, 32'h0);
    lfsr = nextLfsr(lfsr);
    wb(1'b1, tdct_pkg::ADDR_TWO_START, {lfsr, 16'h0001});
    wb(1'b1, tdct_pkg::ADDR_TWO_DIVIDER, 32'h2);
    wb(1'b1, tdct_pkg::ADDR_ONE_CONTROL, 32'h8000);
    tEn = now;
    wb(1'b1, tdct_pkg::ADDR_TWO_CONTROL, 32'hc000);
    for (int k = 2; k >= 0; k--) begin
      wb(1'b1, tdct_pkg::ADDR_TWO_DIVIDER, 32'(k));
      waitTwo(t0);
      waitTwo(t1);
      chk(32'(t1 - t0), 32'((2 * TICK) << k));
    end
    waitTwo(t0);
    wb(1'b1, tdct_pkg::ADDR_TWO_START, 32'h3);
    waitTwo(t1);
    chk(32'(t1 - t0), 32'(4 * TICK));
    chk(32'(oneCount), 32'h1);
    inWin = oneTime - tEn >= (s1 - 1) * TICK - 2 && oneTime - tEn <= s1 * TICK + 3;
    chk(32'(inWin), 32'h1);
    wb(1'b0, tdct_pkg::ADDR_TWO_CONTROL, 32'h0);
    chk(rd, 32'h0000c000);
    wb(1'b1, tdct_pkg::ADDR_TWO_CONTROL, 32'h0);
    wb(1'b0, tdct_pkg::ADDR_FLAGS, 32'h0);
    chk(rd, 32'h00000003);
    wb(1'b0, tdct_pkg::ADDR_FLAGS, 32'h0);
    chk(rd, 32'h00000000);
    // Read back every writable word against the model
    for (int i = 0; i < 10; i++) begin
      if (rwMask(i) != 16'h0000) begin
        wb(1'b0, 6'(i * 4), 32'h0);
        chk(rd, 32'(model[i]));
      end
    end
    wb(1'b1, tdct_pkg::ADDR_THREE_DIVIDER, 32'h0);
    wb(1'b1, tdct_pkg::ADDR_THREE_CONTROL, 32'h1);
    repeat (10 * TICK) @(posedge clk);
    wb(1'b0, tdct_pkg::ADDR_THREE_COUNT, 32'h0);
    chk({31'h0, rd[15:0] >= 16'h0009 && rd[15:0] <= 16'h000b}, 32'h1);
    wb(1'b1, tdct_pkg::ADDR_THREE_CONTROL, 32'h0);
    wb(1'b0, tdct_pkg::ADDR_THREE_COUNT, 32'h0);
    prev = rd;
    wb(1'b1, tdct_pkg::ADDR_THREE_COUNT, {lfsr, 16'hffff});
    wb(1'b0, tdct_pkg::ADDR_THREE_COUNT, 32'h0);
    chk(rd, prev);
    repeat (2600) @(posedge clk);
    wb(1'b0, tdct_pkg::ADDR_THREE_COUNT, 32'h0);
    chk(rd, prev);
    tally_and_finish();
  end
endmodule : tb
